// ==== trace_pkg.sv ====
// shared constants, codes and carriers for the trace update engine
package trace_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NTRACE = 4;
  localparam int PIX_NUM = 500;
  localparam int IDX_W = 9;
  localparam int IN_W = 16;
  localparam int FRAC_W = 8;
  localparam int ACC_W = IN_W + FRAC_W;
  localparam int CNT_W = 15;
  localparam int NUM_W = ACC_W + CNT_W + 1;
  localparam int ADDR_W = 6;

  localparam logic [IDX_W-1:0] PIX_FIRST = 9'h000;
  localparam logic [IDX_W-1:0] PIX_LAST = 9'h1f3;

  ////////////////////////////////////////////////////////////////////////////////
  // sweep counts
  localparam logic [CNT_W-1:0] CNT_ZERO = 15'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 15'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX = 15'h7fff;
  localparam logic [CNT_W-1:0] TOTAL_RST = 15'h000a;
  localparam logic [CNT_W-1:0] SLIDE_K = 15'h0009;
  localparam logic [CNT_W-1:0] SLIDE_DIV = 15'h000a;

  ////////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_TOTAL = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_MODE = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_CMD = 6'h0c;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_SWEEP = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_DET = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_PADDR = 6'h1c;
  localparam logic [ADDR_W-1:0] OFF_PDATA = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_DETOUT = 6'h24;

  // control bit positions
  localparam int CTRL_SCALE = 0;
  localparam int CTRL_INHIBIT = 1;
  localparam int CTRL_REPEAT = 2;
  localparam int CTRL_SPLIT = 3;
  localparam logic [3:0] CTRL_RST = 4'h4;

  // command bit positions
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_PARAM = 2;
  localparam int CMD_COPY = 3;
  localparam int CMD_SRC = 4;
  localparam int CMD_DST = 6;

  ////////////////////////////////////////////////////////////////////////////////
  // trace display modes
  localparam logic [2:0] MODE_BLANK = 3'h0;
  localparam logic [2:0] MODE_VIEW = 3'h1;
  localparam logic [2:0] MODE_WRITE = 3'h2;
  localparam logic [2:0] MODE_AVG = 3'h3;
  localparam logic [2:0] MODE_PEAK = 3'h4;
  localparam logic [2:0] MODE_FLOOR = 3'h5;
  localparam logic [NTRACE*3-1:0] MODE_RST = 12'h002;

  // detector codes
  localparam logic [2:0] DET_AUTO = 3'h0;
  localparam logic [2:0] DET_APEAK = 3'h1;
  localparam logic [2:0] DET_MAXPK = 3'h2;
  localparam logic [2:0] DET_MINPK = 3'h3;
  localparam logic [2:0] DET_SAMPLE = 3'h4;
  localparam logic [NTRACE*3-1:0] DET_RST = 12'h000;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_COPY = 3'b100
  } run_e;

  typedef logic [ACC_W-1:0] acc_t;

  typedef struct packed {
    logic [NTRACE-1:0][IN_W-1:0] value;
  } pix_in_s;

  typedef struct packed {
    logic [NTRACE-1:0][2:0] code;
  } det_out_s;

  // modes that gather over sweeps
  function automatic logic is_accum(input logic [2:0] m);
    return (m == MODE_AVG) | (m == MODE_PEAK) | (m == MODE_FLOOR);
  endfunction

  // modes that take new pixels at all
  function automatic logic is_live(input logic [2:0] m);
    return (m == MODE_WRITE) | is_accum(m);
  endfunction

endpackage

// ==== pixel_combiner.sv ====
// per-pixel arithmetic: overwrite, counted or sliding average, peak and floor
module pixel_combiner import trace_pkg::*; (
  // trace settings
  input wire logic [2:0] mode,
  input wire logic [CNT_W-1:0] n,
  input wire logic [CNT_W-1:0] total,
  // values
  input wire acc_t old,
  input wire logic [IN_W-1:0] meas,
  output acc_t result
);

  // new value in the same fixed point as the stored trace
  acc_t meas_fx;
  logic fresh;
  logic slide;
  logic direct;
  assign meas_fx = {meas, {FRAC_W{1'b0}}};
  assign fresh = (n == CNT_ZERO);
  assign slide = (total == CNT_ZERO);
  assign direct = fresh | (total == CNT_ONE);

  // sweep number m saturates at the total, giving the sliding form afterwards
  logic [CNT_W-1:0] n_inc;
  logic [CNT_W-1:0] m;
  logic [CNT_W-1:0] k;
  assign n_inc = (n == CNT_MAX) ? n : n + CNT_ONE;
  assign m = slide ? SLIDE_DIV : ((n_inc > total) ? total : n_inc);
  assign k = slide ? SLIDE_K : m - CNT_ONE;

  // round to nearest by adding half the divisor; eight fraction bits stop drift
  logic [NUM_W-1:0] num;
  logic [NUM_W-1:0] quo;
  acc_t avg_res;
  assign num = NUM_W'(old) * NUM_W'(k) + NUM_W'(meas_fx) + NUM_W'(m >> 1);
  assign quo = num / NUM_W'(m);
  assign avg_res = direct ? meas_fx : quo[ACC_W-1:0];

  // retention compares
  acc_t peak_res;
  acc_t floor_res;
  assign peak_res = (fresh | (meas_fx > old)) ? meas_fx : old;
  assign floor_res = (fresh | (meas_fx < old)) ? meas_fx : old;

  // mode select; overwrite is the fallback
  assign result = (mode == MODE_AVG) ? avg_res :
                  (mode == MODE_PEAK) ? peak_res :
                  (mode == MODE_FLOOR) ? floor_res : meas_fx;

endmodule

// ==== trace_mem.sv ====
// four flip-flop trace memories with a shared update port and a readout port
module trace_mem import trace_pkg::*; (
  // clock and enable
  input wire logic clk,
  input wire logic ce,
  // shared update port
  input wire logic [IDX_W-1:0] idx,
  input wire logic [NTRACE-1:0] wr_en,
  input wire logic [NTRACE-1:0][ACC_W-1:0] wr_data,
  output logic [NTRACE-1:0][ACC_W-1:0] rd_data,
  // software readout
  input wire logic [1:0] peek_bank,
  input wire logic [IDX_W-1:0] peek_idx,
  output acc_t peek_data
);

  logic [NTRACE-1:0][ACC_W-1:0] peek_all;

  // one bank per trace; caller keeps update indices below the pixel count and masks readout beyond it
  for (genvar b = 0; b < NTRACE; b++) begin : g_bank
    acc_t mem [PIX_NUM];
    always_ff @(posedge clk) begin
      if (ce && wr_en[b]) begin
        mem[idx] <= wr_data[b];
      end
    end
    assign rd_data[b] = mem[idx];
    assign peek_all[b] = mem[peek_idx];
  end

  assign peek_data = peek_all[peek_bank];

endmodule

// ==== trace_sweep_averaging_hold.sv ====
// sweep-by-sweep trace update engine with avalon-mm control
module trace_sweep_averaging_hold import trace_pkg::*; (
  // clock, reset and enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // avalon-mm register slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // pixel stream from the detector stage
  input wire logic pix_valid,
  input wire pix_in_s pix_in,
  output logic pix_ready,
  // status toward the rest of the analyzer
  output det_out_s det_out,
  output logic sweep_done,
  output logic running
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  logic ack_q;
  logic [31:0] readdata_q;
  logic [3:0] ctrl_q;
  logic [CNT_W-1:0] total_q;
  logic [1:0] peek_bank_q;
  logic [IDX_W-1:0] peek_idx_q;
  run_e state_q, state_d;
  logic resume_q, resume_d;
  logic [IDX_W-1:0] pix_idx_q;
  logic [IDX_W-1:0] copy_idx_q;
  logic [CNT_W-1:0] sweep_num_q;
  logic copy_pend_q;
  logic copy_ref_q;
  logic [1:0] copy_src_q;
  logic [1:0] copy_dst_q;
  logic sweep_done_q;
  logic running_q;
  logic [NTRACE-1:0][2:0] mode_v;
  logic [NTRACE-1:0][2:0] det_user_v;
  logic [NTRACE-1:0] hold_v;
  logic [NTRACE-1:0] mem_we;
  logic [NTRACE-1:0][ACC_W-1:0] mem_wd;
  logic [NTRACE-1:0][ACC_W-1:0] mem_rd;
  logic [NTRACE-1:0][ACC_W-1:0] comb_res;
  logic [IDX_W-1:0] mem_idx;
  acc_t peek_data;

  ////////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, then the access completes
  logic req;
  logic wr_fire;
  logic rd_take;
  assign req = read | write;
  assign waitrequest = req & ~(ack_q & ce);
  assign wr_fire = write & ack_q & ce;
  assign rd_take = read & ~ack_q;
  assign readdata = readdata_q;

  // address decode
  logic sel_ctrl, sel_total, sel_mode, sel_cmd, sel_status;
  logic sel_sweep, sel_det, sel_paddr, sel_pdata, sel_detout;
  assign sel_ctrl = (address == OFF_CTRL);
  assign sel_total = (address == OFF_TOTAL);
  assign sel_mode = (address == OFF_MODE);
  assign sel_cmd = (address == OFF_CMD);
  assign sel_status = (address == OFF_STATUS);
  assign sel_sweep = (address == OFF_SWEEP);
  assign sel_det = (address == OFF_DET);
  assign sel_paddr = (address == OFF_PADDR);
  assign sel_pdata = (address == OFF_PDATA);
  assign sel_detout = (address == OFF_DETOUT);

  // commands and change events
  logic cmd_wr, start_cmd, stop_cmd, param_cmd, copy_cmd, scale_chg;
  logic inhibit, repeat_run;
  assign cmd_wr = wr_fire & sel_cmd & byteenable[0];
  assign start_cmd = cmd_wr & writedata[CMD_START];
  assign stop_cmd = cmd_wr & writedata[CMD_STOP];
  assign param_cmd = cmd_wr & writedata[CMD_PARAM];
  assign copy_cmd = cmd_wr & writedata[CMD_COPY];
  assign scale_chg = wr_fire & sel_ctrl & byteenable[0] &
                     (writedata[CTRL_SCALE] != ctrl_q[CTRL_SCALE]);
  assign inhibit = ctrl_q[CTRL_INHIBIT];
  assign repeat_run = ctrl_q[CTRL_REPEAT];

  // copy legality: with split set, paired traces differ only in bit 1 of their index
  logic [1:0] cmd_src, cmd_dst;
  logic copy_ok;
  assign cmd_src = writedata[CMD_SRC +: 2];
  assign cmd_dst = writedata[CMD_DST +: 2];
  assign copy_ok = (cmd_src != cmd_dst) & ~copy_pend_q & (state_q != ST_COPY) &
                   (~ctrl_q[CTRL_SPLIT] | ((cmd_src ^ cmd_dst) == 2'h2));

  ////////////////////////////////////////////////////////////////////////////////
  // pixel intake and sweep bookkeeping
  logic accept, sweep_end, sweep_last, halt, copy_done;
  assign pix_ready = (state_q == ST_RUN) & ~(copy_pend_q & (pix_idx_q == PIX_FIRST));
  assign accept = pix_valid & pix_ready;
  assign sweep_end = accept & (pix_idx_q == PIX_LAST);
  assign sweep_last = (total_q <= CNT_ONE) | (sweep_num_q >= total_q);
  assign halt = sweep_end & sweep_last & ~repeat_run;
  assign copy_done = (state_q == ST_COPY) & (copy_idx_q == PIX_LAST);
  assign mem_idx = (state_q == ST_COPY) ? copy_idx_q : pix_idx_q;

  ////////////////////////////////////////////////////////////////////////////////
  // per-trace mode, restart, write and detector logic
  for (genvar t = 0; t < NTRACE; t++) begin : g_trace
    logic [2:0] mode_q;
    logic [2:0] det_user_q;
    logic [2:0] det_q;
    logic [2:0] det_d;
    logic [2:0] new_mode;
    logic [CNT_W-1:0] n_q;
    logic [CNT_W-1:0] n_cap;
    logic [CNT_W-1:0] n_next;
    logic hold_q;
    logic mode_wr, restart, gate, eng_we, copy_we, dst_done;

    // restart sources; a restart in the same cycle as a write wins
    assign new_mode = writedata[8*t +: 3];
    assign mode_wr = wr_fire & sel_mode & byteenable[t];
    assign restart = (mode_wr & is_live(new_mode)) |
                     (mode_wr & (mode_q == MODE_AVG) & ~is_live(new_mode)) |
                     (scale_chg & (mode_q == MODE_AVG)) |
                     ((scale_chg | param_cmd) & ~inhibit & is_accum(mode_q)) |
                     (start_cmd & is_accum(mode_q));

    // held traces wait for the next sweep's first pixel before writing again
    assign gate = ~hold_q | (pix_idx_q == PIX_FIRST);
    assign eng_we = accept & gate & is_live(mode_q) & ~restart;
    assign copy_we = (state_q == ST_COPY) & (copy_dst_q == 2'(t));
    assign dst_done = copy_done & (copy_dst_q == 2'(t));
    assign mem_we[t] = eng_we | copy_we;
    assign mem_wd[t] = copy_we ? mem_rd[copy_src_q] : comb_res[t];

    // stored-sweep count saturates at the shared total, or at one when the total is zero
    assign n_cap = (total_q == CNT_ZERO) ? CNT_ONE : total_q;
    assign n_next = (n_q < n_cap) ? n_q + CNT_ONE : n_q;

    // retention modes override the user's detector choice
    assign det_d = (mode_q == MODE_PEAK) ? DET_MAXPK :
                   (mode_q == MODE_FLOOR) ? DET_MINPK :
                   (det_user_q != DET_AUTO) ? det_user_q :
                   (mode_q == MODE_AVG) ? DET_SAMPLE : DET_APEAK;

    pixel_combiner u_comb (
      .mode(mode_q),
      .n(n_q),
      .total(total_q),
      .old(mem_rd[t]),
      .meas(pix_in.value[t]),
      .result(comb_res[t])
    );

    // sweep count and clear flag
    always_ff @(posedge clk) begin
      if (rst) begin
        n_q <= CNT_ZERO;
        hold_q <= 1'b0;
      end else if (ce) begin
        if (restart) begin
          n_q <= CNT_ZERO;
          hold_q <= 1'b1;
        end else begin
          if (sweep_end && gate && is_accum(mode_q)) n_q <= n_next;
          if (dst_done || (accept && pix_idx_q == PIX_FIRST)) hold_q <= 1'b0;
        end
      end
    end

    // mode, detector choice and forced detector
    always_ff @(posedge clk) begin
      if (rst) begin
        mode_q <= MODE_RST[3*t +: 3];
        det_user_q <= DET_RST[3*t +: 3];
        det_q <= DET_APEAK;
      end else if (ce) begin
        if (dst_done) mode_q <= MODE_VIEW;
        else if (mode_wr) mode_q <= new_mode;
        if (wr_fire && sel_det && byteenable[t/2]) det_user_q <= writedata[4*t +: 3];
        det_q <= det_d;
      end
    end

    assign mode_v[t] = mode_q;
    assign det_user_v[t] = det_user_q;
    assign hold_v[t] = hold_q;
    assign det_out.code[t] = det_q;
  end

  trace_mem u_mem (
    .clk(clk),
    .ce(ce),
    .idx(mem_idx),
    .wr_en(mem_we),
    .wr_data(mem_wd),
    .rd_data(mem_rd),
    .peek_bank(peek_bank_q),
    .peek_idx(peek_idx_q),
    .peek_data(peek_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // run control; copies wait for a sweep boundary so no sweep is torn
  always_comb begin
    state_d = state_q;
    resume_d = resume_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start_cmd) begin
          state_d = ST_RUN;
        end else if (copy_pend_q) begin
          state_d = ST_COPY;
          resume_d = 1'b0;
        end
      end
      ST_RUN: begin
        if (stop_cmd || halt) begin
          state_d = ST_IDLE;
        end else if (copy_pend_q && pix_idx_q == PIX_FIRST && !start_cmd) begin
          state_d = ST_COPY;
          resume_d = 1'b1;
        end
      end
      ST_COPY: begin
        if (stop_cmd) resume_d = 1'b0;
        else if (start_cmd) resume_d = 1'b1;
        if (copy_idx_q == PIX_LAST) state_d = resume_d ? ST_RUN : ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
        resume_d = 1'b0;
      end
    endcase
  end

  // state, pixel and copy indices
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      resume_q <= 1'b0;
      pix_idx_q <= PIX_FIRST;
      copy_idx_q <= PIX_FIRST;
    end else if (ce) begin
      state_q <= state_d;
      resume_q <= resume_d;
      if (start_cmd || stop_cmd || sweep_end) pix_idx_q <= PIX_FIRST;
      else if (accept) pix_idx_q <= pix_idx_q + 9'h001;
      if (state_q != ST_COPY || copy_done) copy_idx_q <= PIX_FIRST;
      else copy_idx_q <= copy_idx_q + 9'h001;
    end
  end

  // sweep number: counts to the total, then holds there; with a total of 0 or 1 in repeat runs it counts on to the maximum
  always_ff @(posedge clk) begin
    if (rst) begin
      sweep_num_q <= CNT_ZERO;
    end else if (ce) begin
      if (start_cmd) begin
        sweep_num_q <= CNT_ONE;
      end else if (sweep_end) begin
        if (!sweep_last) sweep_num_q <= sweep_num_q + CNT_ONE;
        else if (repeat_run && total_q <= CNT_ONE && sweep_num_q != CNT_MAX)
          sweep_num_q <= sweep_num_q + CNT_ONE;
        else sweep_num_q <= sweep_num_q;
      end
    end
  end

  // copy request latch; a refused request shows in status until the next good one
  always_ff @(posedge clk) begin
    if (rst) begin
      copy_pend_q <= 1'b0;
      copy_ref_q <= 1'b0;
      copy_src_q <= 2'h0;
      copy_dst_q <= 2'h0;
    end else if (ce) begin
      if (state_q != ST_COPY && state_d == ST_COPY) copy_pend_q <= 1'b0;
      if (copy_cmd && copy_ok) begin
        copy_pend_q <= 1'b1;
        copy_ref_q <= 1'b0;
        copy_src_q <= cmd_src;
        copy_dst_q <= cmd_dst;
      end else if (copy_cmd) begin
        copy_ref_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      total_q <= TOTAL_RST;
      peek_bank_q <= 2'h0;
      peek_idx_q <= PIX_FIRST;
    end else if (wr_fire) begin
      if (sel_ctrl && byteenable[0]) ctrl_q <= writedata[3:0];
      if (sel_total && byteenable[0]) total_q[7:0] <= writedata[7:0];
      if (sel_total && byteenable[1]) total_q[14:8] <= writedata[14:8];
      if (sel_paddr && byteenable[1:0] == 2'h3) begin
        peek_idx_q <= writedata[8:0];
        peek_bank_q <= writedata[13:12];
      end
    end
  end

  // readback words; a held trace reads as cleared
  logic [31:0] mode_rd, det_rd, detout_rd, status_rd, sweep_rd, peek_rd, rd_mux;
  logic peek_ok;
  for (genvar t = 0; t < NTRACE; t++) begin : g_rd
    assign mode_rd[8*t +: 8] = {5'h00, mode_v[t]};
    assign det_rd[4*t +: 4] = {1'b0, det_user_v[t]};
    assign detout_rd[4*t +: 4] = {1'b0, det_out.code[t]};
  end
  assign det_rd[31:16] = 16'h0000;
  assign detout_rd[31:16] = 16'h0000;
  assign status_rd = {28'h0000000, copy_pend_q, copy_ref_q,
                      state_q == ST_COPY, state_q != ST_IDLE};
  assign sweep_rd = {1'b0, total_q, 1'b0, sweep_num_q};
  assign peek_ok = (peek_idx_q <= PIX_LAST) & ~hold_v[peek_bank_q];
  assign peek_rd = {8'h00, peek_ok ? peek_data : 24'h000000};
  assign rd_mux = sel_ctrl ? {28'h0000000, ctrl_q} :
                  sel_total ? {17'h00000, total_q} :
                  sel_mode ? mode_rd :
                  sel_status ? status_rd :
                  sel_sweep ? sweep_rd :
                  sel_det ? det_rd :
                  sel_paddr ? {18'h00000, peek_bank_q, 3'h0, peek_idx_q} :
                  sel_pdata ? peek_rd :
                  sel_detout ? detout_rd : 32'h00000000;

  // bus and status flops
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      readdata_q <= 32'h00000000;
      sweep_done_q <= 1'b0;
      running_q <= 1'b0;
    end else if (ce) begin
      ack_q <= req & ~ack_q;
      if (rd_take) readdata_q <= rd_mux;
      sweep_done_q <= sweep_end;
      running_q <= (state_d != ST_IDLE);
    end
  end

  assign sweep_done = sweep_done_q;
  assign running = running_q;

endmodule

// ==== trace_sweep_averaging_hold_properties.sv ====
// port checker for the trace update engine
module trace_sweep_averaging_hold_properties import trace_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // register bus
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic waitrequest,
  // stream and status
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic sweep_done,
  input wire logic running
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] beats_q;
  logic [9:0] beats_d;
  wire take = pix_valid & pix_ready;
  wire cmd = write & ~waitrequest & (address == OFF_CMD);
  ////////////////////////////////////////
  // beats since last sweep end; start or stop rewinds the index
  assign beats_d = (sweep_done | (cmd & |writedata[1:0])) ? 10'(take) : beats_q + 10'(take);
  always_ff @(posedge clk) beats_q <= rst ? 10'h000 : beats_d;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // one wait state only holds while ce stays high
  a_done_pulse: assert property (sweep_done |=> !sweep_done) else $error("done too long");
  a_done_count: assert property (sweep_done |-> beats_q == 10'h1f4)
    else $error("sweep length wrong");
  a_done_cause: assert property (sweep_done |-> $past(take)) else $error("done w/o beat");
  a_ready_run: assert property (pix_ready |-> ##[0:1] running) else $error("ready idle");
  a_bus_answer: assert property ($rose(read | write) ##1 ce |-> !waitrequest)
    else $error("bus stall");
  a_start_runs: assert property (cmd & writedata[CMD_START] |-> ##[1:2] running)
    else $error("no run");
  a_stop_halts: assert property (cmd & (writedata[1:0] == 2'h2) |-> ##[1:2] !pix_ready)
    else $error("no halt");
  a_rst_quiet: assert property ($fell(rst) |-> !running & !sweep_done & !pix_ready)
    else $error("reset state");
  c_sweep: cover property (sweep_done);
  c_copy: cover property (cmd & writedata[CMD_COPY]);
  c_halt: cover property ($fell(running));
endmodule
bind trace_sweep_averaging_hold trace_sweep_averaging_hold_properties
  trace_sweep_averaging_hold_properties_i (.clk, .rst, .ce, .address, .read, .write,
  .writedata, .waitrequest, .pix_valid, .pix_ready, .sweep_done, .running);

// ==== pixel_source.sv ====
// detector stage stand-in: one sweep of pixels per go pulse
module pixel_source import trace_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench control
  input wire logic go,
  input wire logic slow,
  // stream toward the engine
  input wire logic pix_ready,
  output logic pix_valid,
  output pix_in_s pix_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int left;
  // data held while stalled; idle lines flip so no stale value passes
  always @(posedge clk) begin : src
    int n;
    logic v;
    n = go ? 500 : left - int'(pix_valid && pix_ready);
    v = n > 0 && !(slow && $urandom_range(1) == 1);
    left <= n;
    if (rst) begin
      left <= 0;
      pix_valid <= 1'b0;
      pix_in <= '0;
    end else if (pix_ready || !pix_valid) begin
      pix_valid <= v;
      pix_in <= v ? {$urandom, $urandom} : ~pix_in;
    end
  end
endmodule

// ==== trace_sweep_averaging_hold_bench.sv ====
// self-checking bench: engine, pixel source and reference model
module trace_sweep_averaging_hold_bench import trace_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, go = 1'b0, slow = 1'b0;
  logic [ADDR_W-1:0] address = 6'h00;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic waitrequest, pix_valid, pix_ready, sweep_done, running;
  pix_in_s pix_in;
  det_out_s det_out;
  int mismatches = 0, total_checks = 0, px = 0, tot = 10, s, mv[4][500], k[4];
  logic [2:0] md[4];
  `define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
  always #2 clk = ~clk;
  trace_sweep_averaging_hold trace_sweep_averaging_hold_i (.clk, .rst, .ce(1'b1), .address,
    .read, .write, .writedata, .byteenable(4'hf), .readdata, .waitrequest, .pix_valid,
    .pix_in, .pix_ready, .det_out, .sweep_done, .running);
  pixel_source pixel_source_i (.clk, .rst, .go, .slow, .pix_ready, .pix_valid, .pix_in);
  ////////////////////////////////////////
  // reference model, fed from every accepted beat
  always @(posedge clk) begin : model
    int x, o, m;
    if (!rst && pix_valid && pix_ready) begin
      for (int t = 0; t < 4; t++) begin
        x = int'(pix_in.value[t]) << 8;
        o = mv[t][px];
        m = (k[t] + 1 < tot) ? k[t] + 1 : tot;
        case (md[t])
          MODE_WRITE: o = x;
          MODE_AVG: o = (k[t] == 0 || tot == 1) ? x : (tot == 0) ? (9 * o + x + 5) / 10 :
            ((m - 1) * o + x + m / 2) / m;
          MODE_PEAK: o = (k[t] == 0 || x > o) ? x : o;
          MODE_FLOOR: o = (k[t] == 0 || x < o) ? x : o;
          default: ;
        endcase
        mv[t][px] = o;
      end
      px = (px == 499) ? 0 : px + 1;
    end
    if (sweep_done === 1'b1) foreach (k[t]) k[t]++;
  end
  ////////////////////////////////////////
  task automatic stop_on(input logic bad);
    if (bad) begin
      mismatches++;
      test_done();
    end
  endtask
  // one access, request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    @(posedge clk);
    for (n = 0; waitrequest !== 1'b0 && n < 50; n++) @(posedge clk);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
    stop_on(n == 50);
  endtask
  task automatic sweep;
    int n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (n = 0; sweep_done !== 1'b1 && n < 3000; n++) @(posedge clk);
    stop_on(n == 3000);
    @(posedge clk);
  endtask
  // a cleared trace reads back as zero
  task automatic rs(input logic [3:0] m);
    foreach (k[t])
      if (m[t]) begin
        k[t] = 0;
        for (int i = 0; i < 500; i++) mv[t][i] = 0;
      end
  endtask
  task automatic chk_mem;
    for (int t = 0; t < 4; t++)
      for (int i = 1; i < 500; i += 6) begin
        bus(1'b1, OFF_PADDR, 32'(t * 4096 + i));
        bus(1'b0, OFF_PDATA, 32'h0);
        `CHK("pixel", mv[t][i], q[23:0])
      end
  endtask
  task automatic cpy(input int a, input int d);
    int n;
    bus(1'b1, OFF_CMD, 32'(8 + a * 16 + d * 64));
    for (n = 0; n < 300; n++) begin
      bus(1'b0, OFF_STATUS, 32'h0);
      if (q[3:1] === 3'h0) break;
    end
    stop_on(n == 300);
    mv[d] = mv[a];
    md[d] = MODE_VIEW;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h8bb7));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, OFF_TOTAL, 32'h0);
    `CHK("total", 32'(TOTAL_RST), q)
    tot = 3;
    bus(1'b1, OFF_TOTAL, 32'h3);
    bus(1'b1, OFF_MODE, 32'h05040302);
    md = '{MODE_WRITE, MODE_AVG, MODE_PEAK, MODE_FLOOR};
    rs(4'hf);
    @(posedge clk);
    `CHK("det", 12'h6a1, det_out)
    bus(1'b1, OFF_CMD, 32'h1);
    for (s = 1; s <= 5; s++) begin
      slow <= s[0];
      sweep();
      bus(1'b0, OFF_SWEEP, 32'h0);
      `CHK("sweep", {16'(tot), 16'(s < 3 ? s + 1 : 3)}, q)
      if (s % 2) chk_mem();
    end
    tot = 0;
    bus(1'b1, OFF_TOTAL, 32'h0);
    sweep();
    sweep();
    chk_mem();
    // parameter change clears gathering traces, overwrite trace untouched
    bus(1'b1, OFF_CMD, 32'h4);
    rs(4'he);
    chk_mem();
    sweep();
    bus(1'b1, OFF_CTRL, 32'h6);
    bus(1'b1, OFF_CMD, 32'h4);
    bus(1'b1, OFF_CTRL, 32'h7);
    rs(4'h2);
    chk_mem();
    sweep();
    cpy(0, 2);
    bus(1'b1, OFF_CTRL, 32'hf);
    bus(1'b1, OFF_CMD, 32'h48);
    bus(1'b0, OFF_STATUS, 32'h0);
    `CHK("refused", 1'b1, q[2])
    cpy(1, 3);
    bus(1'b0, OFF_MODE, 32'h0);
    `CHK("mode", 32'h01010302, q)
    chk_mem();
    // one-shot run of two sweeps must halt by itself
    bus(1'b1, OFF_CMD, 32'h2);
    bus(1'b1, OFF_CTRL, 32'h0);
    tot = 2;
    bus(1'b1, OFF_TOTAL, 32'h2);
    bus(1'b1, OFF_CMD, 32'h1);
    rs(4'h2);
    sweep();
    sweep();
    repeat (2) @(posedge clk);
    `CHK("running", 1'b0, running)
    bus(1'b0, OFF_SWEEP, 32'h0);
    `CHK("sweep", 32'h00020002, q)
    chk_mem();
    // leaving averaging for blank clears it; reselecting overwrite clears too
    bus(1'b1, OFF_MODE, 32'h01010002);
    rs(4'h3);
    md[1] = MODE_BLANK;
    chk_mem();
    test_done();
  end
endmodule
